/* pms_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pms_assertions
  import pms_pkg::*;
(
  input wire logic         SYS_CLK_I,
  input wire logic         RST_N_I,
  input wire pms_avs_req_t AVS_REQ_I,
  input wire logic         AVS_WAITREQUEST_O,
  input wire logic         STD_SW_I,
  input wire logic         DEVTYPE_SW_I,
  input wire logic         DET_DONE_I,
  input wire logic         CONSOLE_PRESENT_I,
  input wire logic         OTHER_DEV_PRESENT_I,
  input wire logic         CABLE_RUN_I,
  input wire logic [1:0]   CONSOLE_MODE_I,
  input wire logic [1:0]   LAST_MODE_I,
  input wire pms_result_t  RESULT_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // Inputs one cycle back, since the result appears the cycle after they were latched.
  logic [9:0]  q;
  logic [15:0] sw;
  logic        done_q;
  always_ff @(posedge SYS_CLK_I) begin
    q <= {LAST_MODE_I, CONSOLE_MODE_I, CABLE_RUN_I, OTHER_DEV_PRESENT_I, CONSOLE_PRESENT_I, DET_DONE_I,
          DEVTYPE_SW_I, STD_SW_I};
    if (!RST_N_I) begin
      sw <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      done_q <= RESULT_O.done;
      if (AVS_REQ_I.write && !AVS_WAITREQUEST_O && AVS_REQ_I.address == 8'h00) begin
        if (AVS_REQ_I.byteenable[0]) sw[7:0] <= AVS_REQ_I.writedata[7:0];
        if (AVS_REQ_I.byteenable[1]) sw[15:8] <= AVS_REQ_I.writedata[15:8];
      end
    end
  end
  wire ev = RESULT_O.done & ~done_q;
  wire s0 = ev && sw[15:8] == 8'h00;
  property p_per_con; ev && !q[1] |-> RESULT_O.periph_mask == 6'h01; endproperty
  a_per_con: assert property (p_per_con) else $error("peripheral mask not console only");
  property p_per_set; ev && !q[0] && q[1] |-> RESULT_O.periph_mask == 6'h0e; endproperty
  a_per_set: assert property (p_per_set) else $error("peripheral mask wrong with setup words");
  property p_per_std; ev && q[0] && q[1] |-> RESULT_O.periph_mask == 6'h06 && !RESULT_O.periph_setup_src; endproperty
  a_per_std: assert property (p_per_std) else $error("peripheral standard set wrong");
  property p_rs_set; ev && !q[0] |-> RESULT_O.rs232_mask == 6'h3c && RESULT_O.rs232_setup_src; endproperty
  a_rs_set: assert property (p_rs_set) else $error("serial port setup mode wrong");
  property p_rs_std; ev && q[0] |-> RESULT_O.rs232_mask == 6'h04 && !RESULT_O.rs232_setup_src; endproperty
  a_rs_std: assert property (p_rs_std) else $error("serial port standard mode wrong");
  property p_det; ev |-> q[2] ##1 $stable(RESULT_O); endproperty
  a_det: assert property (p_det) else $error("result before detection or not held");
  property p_last; ev && sw[15:8] == 8'h01 |-> RESULT_O.startup_mode == q[9:8]; endproperty
  a_last: assert property (p_last) else $error("last mode not used");
  property p_expl; ev && sw[15:8] == 8'h02 && sw[7:0] < 8'h03 |-> RESULT_O.startup_mode == sw[1:0]; endproperty
  a_expl: assert property (p_expl) else $error("explicit mode not used");
  property p_none; s0 && !q[3] && !q[4] |-> RESULT_O.startup_mode == {q[1], 1'b0}; endproperty
  a_none: assert property (p_none) else $error("mode wrong with nothing attached");
  property p_con;
    s0 && q[3] |-> RESULT_O.startup_mode == (q[1] ? 2'h0 : q[7:6]) && RESULT_O.console_comm == !q[1];
  endproperty
  a_con: assert property (p_con) else $error("mode wrong with console");
  property p_oth; s0 && !q[3] && q[4] |-> RESULT_O.startup_mode == {q[1] & q[5], 1'b0}; endproperty
  a_oth: assert property (p_oth) else $error("mode wrong with other device");
  c_sel0: cover property (s0);
  c_sel1: cover property (ev && sw[15:8] == 8'h01);
  c_sel2: cover property (ev && sw[15:8] == 8'h02);
endmodule : pms_assertions
`default_nettype wire

/* pms_consts.svh */
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// Register byte offsets on the slave port.
`define PMS_OFS_STARTUP     8'h00
`define PMS_OFS_PERIPH      8'h04
`define PMS_OFS_CTRL        8'h08
`define PMS_OFS_STATUS      8'h0c
`define PMS_OFS_STDPAR      8'h10

// Reset values of the setup words.
`define PMS_RST_STARTUP     16'h0000
`define PMS_RST_PERIPH      16'h0000

// Startup selector (bits 15:8) and explicit mode field (bits 7:0).
`define PMS_SEL_HI          15
`define PMS_SEL_LO          8
`define PMS_MODE_HI         7
`define PMS_MODE_LO         0
`define PMS_SEL_SWITCH      8'h00
`define PMS_SEL_LAST        8'h01
`define PMS_SEL_EXPLICIT    8'h02

// Operating mode codes.
`define PMS_MODE_PROGRAM    2'h0
`define PMS_MODE_MONITOR    2'h1
`define PMS_MODE_RUN        2'h2

// Peripheral port setup word values.
`define PMS_PERIPH_STD      16'h0000
`define PMS_PERIPH_CUSTOM   16'h0001

// Bits of a serial mode mask.
`define PMS_M_CONSOLE       0
`define PMS_M_PBUS          1
`define PMS_M_HOSTLINK      2
`define PMS_M_NOPROTO       3
`define PMS_M_DATALINK      4
`define PMS_M_TERMLINK      5

// Control register bit.
`define PMS_CTRL_GO         0

// Status register fields.
`define PMS_ST_DONE         0
`define PMS_ST_MODE_LO      1
`define PMS_ST_CONSOLE      3
`define PMS_ST_PSRC         4
`define PMS_ST_RSRC         5
`define PMS_ST_PMASK_LO     6
`define PMS_ST_RMASK_LO     12

// Standard parameter set, as read from the standard parameter register.
`define PMS_STD_START       4'h1
`define PMS_STD_DATA        4'h7
`define PMS_STD_STOP        4'h2
`define PMS_STD_PARITY      4'h2
`define PMS_STD_BAUD        16'h2580
`define PMS_SP_START_LO     0
`define PMS_SP_DATA_LO      4
`define PMS_SP_STOP_LO      8
`define PMS_SP_PARITY_LO    12
`define PMS_SP_BAUD_LO      16

`endif

/* pms_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pms_dev_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] kind_i,
  input  wire logic       cable_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [3:0] lat_i,
  output logic            console_o,
  output logic            other_o,
  output logic            cable_run_o,
  output logic [1:0]      mode_o,
  output logic            det_o
);
  logic [3:0] cnt;
  always_ff @(posedge clk_i) begin
    cnt <= rst_n_i ? cnt + 4'h1 : 4'h0;
    det_o <= rst_n_i & (det_o | cnt == lat_i);
  end
  assign console_o = kind_i == 2'h1;
  assign other_o = kind_i == 2'h2;
  // Lines of an absent device wander, so a stale level is never taken for a report.
  assign cable_run_o = other_o ? cable_i : cnt[0];
  assign mode_o = console_o ? mode_i : cnt[1:0];
endmodule : pms_dev_model
`default_nettype wire

/* pms_pkg.sv */
`default_nettype none
package pms_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_DET,
    ST_DONE
  } pms_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pms_avs_req_t;

  typedef struct packed {
    logic       done;
    logic [1:0] startup_mode;
    logic       console_comm;
    logic       periph_setup_src;
    logic       rs232_setup_src;
    logic [5:0] periph_mask;
    logic [5:0] rs232_mask;
  } pms_result_t;

  typedef struct packed {
    pms_state_t  state;
    logic [15:0] startup_word;
    logic [15:0] periph_word;
    logic        ack;
    logic [31:0] rdata;
    pms_result_t result;
  } pms_regs_t;

endpackage : pms_pkg
`default_nettype wire

/* pms_port_startup_sel.sv */
// Notes on behaviour
// - Device-type switch off: peripheral port offers only the console bus.
// - Std off, device on: peripheral uses setup words; peripheral bus, host link, no-protocol.
// - Both on: peripheral uses standard parameters; peripheral bus or host link only.
// - Peripheral bus runs host link; peripheral word selects standard or custom.
// - Std switch off: RS-232C parameters come from its setup words.
// - Std off: RS-232C allows host, no-protocol, data link, terminal link.
// - Std on: RS-232C uses standard parameters, host link only.
// - Selector bits 15:8: 00 switch-dependent, 01 last mode, 02 explicit field.
// - Explicit field bits 7:0: 00 program, 01 monitor, 02 run.
// - Selector 00: mode fixed once console presence is determined.
// - Nothing attached: program if device switch off, run if on.
// - Console attached, device switch off: follow console mode switch.
// - Console attached, device switch on: program, no console communication.
// - Other device, device switch off: program, no communication with it.
// - Other device, device switch on: program or run by cable type.
// - Standard set: host link, 1 start, even, 7 data, 2 stop, 9600.
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.svh"

module pms_port_startup_sel
  import pms_pkg::*;
(
  input  wire logic         SYS_CLK_I,
  input  wire logic         RST_N_I,
  input  wire pms_avs_req_t AVS_REQ_I,
  output logic              AVS_WAITREQUEST_O,
  output logic [31:0]       AVS_READDATA_O,
  input  wire logic         STD_SW_I,
  input  wire logic         DEVTYPE_SW_I,
  input  wire logic         DET_DONE_I,
  input  wire logic         CONSOLE_PRESENT_I,
  input  wire logic         OTHER_DEV_PRESENT_I,
  input  wire logic         CABLE_RUN_I,
  input  wire logic [1:0]   CONSOLE_MODE_I,
  input  wire logic [1:0]   LAST_MODE_I,
  output pms_result_t       RESULT_O
);

  pms_regs_t r;
  pms_regs_t next_r;

  logic req;
  assign req = AVS_REQ_I.read | AVS_REQ_I.write;

  // One wait cycle per access gives the read data a flop stage to settle in.
  assign AVS_WAITREQUEST_O = req & ~r.ack;
  assign AVS_READDATA_O    = r.rdata;
  assign RESULT_O          = r.result;

  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] data,
                                       input logic [3:0]  be);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = data[7:0];
    end
    if (be[1]) begin
      v[15:8] = data[15:8];
    end
    return v;
  endfunction : wr16

  function automatic logic [5:0] periph_mask(input logic std_sw,
                                             input logic dev_sw);
    logic [5:0] m;
    m = 6'h00;
    if (!dev_sw) begin
      m[`PMS_M_CONSOLE] = 1'b1;
    end else if (!std_sw) begin
      m[`PMS_M_PBUS]     = 1'b1;
      m[`PMS_M_HOSTLINK] = 1'b1;
      m[`PMS_M_NOPROTO]  = 1'b1;
    end else begin
      m[`PMS_M_PBUS]     = 1'b1;
      m[`PMS_M_HOSTLINK] = 1'b1;
    end
    return m;
  endfunction : periph_mask

  function automatic logic [5:0] rs232_mask(input logic std_sw);
    logic [5:0] m;
    m = 6'h00;
    m[`PMS_M_HOSTLINK] = 1'b1;
    if (!std_sw) begin
      m[`PMS_M_NOPROTO]  = 1'b1;
      m[`PMS_M_DATALINK] = 1'b1;
      m[`PMS_M_TERMLINK] = 1'b1;
    end
    return m;
  endfunction : rs232_mask

  // Unknown codes fall back to program mode, the safe choice at power-up.
  function automatic logic [1:0] mode_code(input logic [7:0] f);
    logic [1:0] m;
    m = `PMS_MODE_PROGRAM;
    if (f == {6'h00, `PMS_MODE_MONITOR}) begin
      m = `PMS_MODE_MONITOR;
    end else if (f == {6'h00, `PMS_MODE_RUN}) begin
      m = `PMS_MODE_RUN;
    end
    return m;
  endfunction : mode_code

  function automatic logic [1:0] switch_mode(input logic dev_sw,
                                             input logic console,
                                             input logic other,
                                             input logic cable_run,
                                             input logic [1:0] cons_mode);
    logic [1:0] m;
    m = `PMS_MODE_PROGRAM;
    if (console) begin
      if (!dev_sw) begin
        m = cons_mode;
      end
    end else if (other) begin
      if (dev_sw && cable_run) begin
        m = `PMS_MODE_RUN;
      end
    end else begin
      m = dev_sw ? `PMS_MODE_RUN : `PMS_MODE_PROGRAM;
    end
    return m;
  endfunction : switch_mode

  logic [31:0] status_word;
  logic [31:0] stdpar_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`PMS_ST_DONE] = r.result.done;
    status_word[`PMS_ST_MODE_LO +: 2] = r.result.startup_mode;
    status_word[`PMS_ST_CONSOLE] = r.result.console_comm;
    status_word[`PMS_ST_PSRC] = r.result.periph_setup_src;
    status_word[`PMS_ST_RSRC] = r.result.rs232_setup_src;
    status_word[`PMS_ST_PMASK_LO +: 6] = r.result.periph_mask;
    status_word[`PMS_ST_RMASK_LO +: 6] = r.result.rs232_mask;
  end

  always_comb begin
    stdpar_word = 32'h0000_0000;
    stdpar_word[`PMS_SP_START_LO +: 4]  = `PMS_STD_START;
    stdpar_word[`PMS_SP_DATA_LO +: 4]   = `PMS_STD_DATA;
    stdpar_word[`PMS_SP_STOP_LO +: 4]   = `PMS_STD_STOP;
    stdpar_word[`PMS_SP_PARITY_LO +: 4] = `PMS_STD_PARITY;
    stdpar_word[`PMS_SP_BAUD_LO +: 16]  = `PMS_STD_BAUD;
  end

  logic [7:0] sel;
  assign sel = r.startup_word[`PMS_SEL_HI:`PMS_SEL_LO];

  always_comb begin
    next_r = r;

    // Bus slave: wait cycle latches read data, accept cycle commits.
    if (req && !r.ack) begin
      next_r.ack = 1'b1;
      case (AVS_REQ_I.address)
        `PMS_OFS_STARTUP: next_r.rdata = {16'h0000, r.startup_word};
        `PMS_OFS_PERIPH:  next_r.rdata = {16'h0000, r.periph_word};
        `PMS_OFS_CTRL:    next_r.rdata = {31'h0, r.state != ST_IDLE};
        `PMS_OFS_STATUS:  next_r.rdata = status_word;
        `PMS_OFS_STDPAR:  next_r.rdata = stdpar_word;
        default:          next_r.rdata = 32'h0000_0000;
      endcase
    end else if (r.ack) begin
      next_r.ack = 1'b0;
    end

    if (req && r.ack && AVS_REQ_I.write) begin
      case (AVS_REQ_I.address)
        `PMS_OFS_STARTUP: begin
          next_r.startup_word = wr16(r.startup_word, AVS_REQ_I.writedata, AVS_REQ_I.byteenable);
        end
        `PMS_OFS_PERIPH: begin
          next_r.periph_word = wr16(r.periph_word, AVS_REQ_I.writedata, AVS_REQ_I.byteenable);
        end
        `PMS_OFS_CTRL: begin
          if (r.state == ST_IDLE && AVS_REQ_I.byteenable[0] &&
              AVS_REQ_I.writedata[`PMS_CTRL_GO]) begin
            next_r.state = ST_WAIT_DET;
          end
        end
        default: begin
        end
      endcase
    end

    case (r.state)
      ST_IDLE: begin
      end
      ST_WAIT_DET: begin
        if (DET_DONE_I) begin
          next_r.state = ST_DONE;
          next_r.result.done = 1'b1;
          case (sel)
            `PMS_SEL_SWITCH: begin
              next_r.result.startup_mode = switch_mode(DEVTYPE_SW_I, CONSOLE_PRESENT_I,
                                                       OTHER_DEV_PRESENT_I, CABLE_RUN_I,
                                                       CONSOLE_MODE_I);
            end
            `PMS_SEL_LAST: begin
              next_r.result.startup_mode = LAST_MODE_I;
            end
            `PMS_SEL_EXPLICIT: begin
              next_r.result.startup_mode = mode_code(r.startup_word[`PMS_MODE_HI:`PMS_MODE_LO]);
            end
            default: begin
              next_r.result.startup_mode = `PMS_MODE_PROGRAM;
            end
          endcase
          // console talks only with device switch off
          next_r.result.console_comm = CONSOLE_PRESENT_I & ~DEVTYPE_SW_I;
          next_r.result.periph_mask = periph_mask(STD_SW_I, DEVTYPE_SW_I);
          next_r.result.rs232_mask = rs232_mask(STD_SW_I);
          // standard or custom by peripheral word
          next_r.result.periph_setup_src = DEVTYPE_SW_I & ~STD_SW_I &
                                           (r.periph_word == `PMS_PERIPH_CUSTOM);
          next_r.result.rs232_setup_src = ~STD_SW_I;
        end
      end
      ST_DONE: begin
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      r.state        <= ST_IDLE;
      r.startup_word <= `PMS_RST_STARTUP;
      r.periph_word  <= `PMS_RST_PERIPH;
      r.ack          <= 1'b0;
      r.rdata        <= 32'h0000_0000;
      r.result       <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule : pms_port_startup_sel
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pms_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  pms_avs_req_t req = '0;
  logic         wt, s, v, c, con, oth, cab, det;
  logic [31:0]  rdata, rd;
  logic [1:0]   k, cm, lm, cmo;
  logic [3:0]   lat;
  pms_result_t  res;
  int           errors = 0;
  int           cmp_count = 0;
  always #12.5 clk = ~clk;
  pms_port_startup_sel dut_u (.SYS_CLK_I(clk), .RST_N_I(rst_n), .AVS_REQ_I(req), .AVS_WAITREQUEST_O(wt),
    .AVS_READDATA_O(rdata), .STD_SW_I(s), .DEVTYPE_SW_I(v), .DET_DONE_I(det), .CONSOLE_PRESENT_I(con),
    .OTHER_DEV_PRESENT_I(oth), .CABLE_RUN_I(cab), .CONSOLE_MODE_I(cmo), .LAST_MODE_I(lm), .RESULT_O(res));
  pms_dev_model dev_u (.clk_i(clk), .rst_n_i(rst_n), .kind_i(k), .cable_i(c), .mode_i(cm), .lat_i(lat),
    .console_o(con), .other_o(oth), .cable_run_o(cab), .mode_o(cmo), .det_o(det));
  task automatic results;
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
    // The request stands until the rising edge that sees waitrequest low; data is taken there.
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (n >= 20) errors++;
    rd = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask : bus
  function automatic pms_result_t expect_res(input logic [15:0] sw, input logic [15:0] pw);
    pms_result_t r;
    r = '0;
    r.done = 1'b1;
    r.console_comm = k == 2'h1 && !v;
    r.periph_mask = !v ? 6'h01 : s ? 6'h06 : 6'h0e;
    r.periph_setup_src = !s && v && pw == 16'h0001;
    r.rs232_mask = s ? 6'h04 : 6'h3c;
    r.rs232_setup_src = !s;
    case (sw[15:8])
      8'h00: r.startup_mode = k == 2'h1 ? (v ? 2'h0 : cm) : {v & (k != 2'h2 | c), 1'b0};
      8'h01: r.startup_mode = lm;
      8'h02: r.startup_mode = sw[7:0] > 8'h02 ? 2'h0 : sw[1:0];
      default: r.startup_mode = 2'h0;
    endcase
    return r;
  endfunction : expect_res
  task automatic run_case(input logic [15:0] sw, input logic [15:0] pw);
    pms_result_t e;
    int n;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    e = expect_res(sw, pw);
    @(posedge clk);
    bus(1'b1, 8'h00, {16'h0000, sw});
    bus(1'b1, 8'h04, {16'h0000, pw});
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, {16'h0000, sw});
    bus(1'b1, 8'h08, 32'h1);
    n = 0;
    while (res.done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk({14'h0, res}, {14'h0, e});
    @(posedge clk);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, {14'h0, e.rs232_mask, e.periph_mask, e.rs232_setup_src, e.periph_setup_src, e.console_comm,
        e.startup_mode, e.done});
  endtask : run_case
  initial begin
    int r;
    {s, v, c, k, cm, lm, lat} = '0;
    void'($urandom(68177));
    @(posedge clk);
    // Every switch, device and cable pairing with the switch-driven selector.
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      {cm, lm, lat} <= r[7:0];
      {k, c, v, s} <= i[4:0];
      run_case(16'h0000, {15'h0, i[2]});
    end
    for (int i = 0; i < 12; i++) begin
      r = $urandom;
      {s, v, c, k, cm, lm, lat} <= r[12:0];
      run_case({8'(i / 4 + 1), 8'(i % 4)}, 16'h0001);
    end
    for (int i = 0; i < 30; i++) begin
      r = $urandom;
      {s, v, c, k, cm, lm, lat} <= r[12:0];
      run_case({6'h0, r[14:13], 6'h0, r[16:15]}, {14'h0, r[18:17]});
    end
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h2580_2271);
    bus(1'b1, 8'h14, 32'hffff_ffff);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0000_0000);
    results();
  end
  // Whole run needs under two thousand cycles; twenty thousand means a hang.
  initial begin
    #500000;
    errors++;
    results();
  end
endmodule : tb_top
bind pms_port_startup_sel pms_assertions chk_u (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
  .AVS_REQ_I(AVS_REQ_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .STD_SW_I(STD_SW_I),
  .DEVTYPE_SW_I(DEVTYPE_SW_I), .DET_DONE_I(DET_DONE_I), .CONSOLE_PRESENT_I(CONSOLE_PRESENT_I),
  .OTHER_DEV_PRESENT_I(OTHER_DEV_PRESENT_I), .CABLE_RUN_I(CABLE_RUN_I), .CONSOLE_MODE_I(CONSOLE_MODE_I),
  .LAST_MODE_I(LAST_MODE_I), .RESULT_O(RESULT_O));
`default_nettype wire
